// *** rtl/tcpp_defs.svh ***
// Offsets, field positions, reset values and load constants of the compare block
// Behaviour
// - A compare match sets the channel flag, drives its level, may interrupt.
// - Compare registers are 16 bits, software owned, reset to 8000h.
// - Compare pin latches are held low during reset.
// - A flag clears after a status read then a low byte access.
// - Writing the high byte inhibits compares until the low byte is written.
// - With the pin disabled, flag and interrupt still occur but no drive.
// - Match at count equal value (divide by 2), else value plus 1.
// - Force bit copies level to an enabled pin, no flag, no interrupt.
// - Force bits are ignored in one-pulse and modulation modes.
// - One-pulse mode triggers on capture one, times with compare one.
// - Trigger loads counter FFFCh, drives during level, capture FFFDh, flag.
// - In one-pulse mode compare one match drives the after level.
// - Pulse or period lasts the compare value plus five ticks.
// - One-pulse mode never sets compare flag one; compare flag two still sets.
// - With both mode bits set, only modulation mode runs.
// - Special modes disable capture one; capture two keeps working.
// - Modulation mode buffers compare writes until the period ends.
// - Modulation mode reloads the counter with FFFCh on match two.
// - Modulation output takes level one on match one, level two on two.
// - Modulation mode never sets compare flags.
// - Modulation mode sets capture flag one at each period end.
// - Tick is CPU clock over 2, 4, 8 or an external clock.
// - External clock is selected when both select bits are one.
`ifndef TCPP_DEFS_SVH
`define TCPP_DEFS_SVH

// ==========================================================================
// Register byte offsets
`define TCPP_CTL1_OFF  8'h00
`define TCPP_CTL2_OFF  8'h04
`define TCPP_STAT_OFF  8'h08
`define TCPP_CMP1H_OFF 8'h0c
`define TCPP_CMP1L_OFF 8'h10
`define TCPP_CMP2H_OFF 8'h14
`define TCPP_CMP2L_OFF 8'h18
`define TCPP_CAP1H_OFF 8'h1c
`define TCPP_CAP1L_OFF 8'h20
`define TCPP_CAP2H_OFF 8'h24
`define TCPP_CAP2L_OFF 8'h28
`define TCPP_CNTH_OFF  8'h2c
`define TCPP_CNTL_OFF  8'h30

// ==========================================================================
// Control one fields
`define TCPP_C1_CAPIE  7
`define TCPP_C1_CMPIE  6
`define TCPP_C1_OVFIE  5
`define TCPP_C1_FORCE2 4
`define TCPP_C1_FORCE1 3
`define TCPP_C1_LVL2   2
`define TCPP_C1_EDGE1  1
`define TCPP_C1_LVL1   0

// Control two fields
`define TCPP_C2_PINEN1 7
`define TCPP_C2_PINEN2 6
`define TCPP_C2_PULSE  5
`define TCPP_C2_PWM    4
`define TCPP_C2_TICKHI 3
`define TCPP_C2_TICKLO 2
`define TCPP_C2_EDGE2  1
`define TCPP_C2_EXEDGE 0

// ==========================================================================
// Reset and load values
`define TCPP_CTL_RST   8'h00
`define TCPP_CMP_RST   16'h8000
`define TCPP_CNT_LOAD  16'hfffc
`define TCPP_CAP_PULSE 16'hfffd
`define TCPP_CNT_TOP   16'hffff

`endif

// *** rtl/tcpp_pkg.sv ***
// Types shared by the compare block
package tcpp_pkg;

   typedef logic [15:0] tcpp_word_t;

   // Gray ordered: normal, one-pulse, modulation
   typedef enum logic [1:0] {
      TCPP_NORMAL = 2'b00,
      TCPP_PULSE  = 2'b01,
      TCPP_PWM    = 2'b11
   } tcpp_mode_t;

endpackage

// *** rtl/tcpp_timer.sv ***
// Timer compare, one-pulse and modulation block with APB registers
`timescale 1ns/1ps
`default_nettype none
`include "tcpp_defs.svh"

module tcpp_timer (
   // APB
   input  wire logic              pclk,
   input  wire logic              presetn,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Pins
   input  wire logic              capture_input_one,
   input  wire logic              capture_input_two,
   input  wire logic              ext_clk_in,
   output logic      [1:0]        compare_output_pin,
   output logic      [1:0]        compare_pin_enable,
   // Processor side
   input  wire logic              irq_global_mask,
   output logic                   timer_irq,
   output tcpp_pkg::tcpp_mode_t   mode_now
);
   import tcpp_pkg::*;

   // =======================================================================
   // Decode
   function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
      hit = (a == o);
   endfunction

   wire       acc    = psel & penable;
   wire       wr     = acc & pwrite;
   wire       rd     = acc & ~pwrite;
   wire [7:0] wbyte  = pwdata[7:0];
   wire       ctl1_w = wr & hit(paddr, `TCPP_CTL1_OFF);
   wire       ctl2_w = wr & hit(paddr, `TCPP_CTL2_OFF);
   wire       stat_r = rd & hit(paddr, `TCPP_STAT_OFF);
   wire       cnt_lo = acc & hit(paddr, `TCPP_CNTL_OFF);
   wire       cnt_lw = wr & hit(paddr, `TCPP_CNTL_OFF);
   wire [1:0] cmp_hw = {wr & hit(paddr, `TCPP_CMP2H_OFF),
                        wr & hit(paddr, `TCPP_CMP1H_OFF)};
   wire [1:0] cmp_lw = {wr & hit(paddr, `TCPP_CMP2L_OFF),
                        wr & hit(paddr, `TCPP_CMP1L_OFF)};
   wire [1:0] cmp_la = {acc & hit(paddr, `TCPP_CMP2L_OFF),
                        acc & hit(paddr, `TCPP_CMP1L_OFF)};
   wire [1:0] cap_hr = {rd & hit(paddr, `TCPP_CAP2H_OFF),
                        rd & hit(paddr, `TCPP_CAP1H_OFF)};
   wire [1:0] cap_la = {acc & hit(paddr, `TCPP_CAP2L_OFF),
                        acc & hit(paddr, `TCPP_CAP1L_OFF)};
   wire       addr_ok = (paddr <= `TCPP_CNTL_OFF) && (paddr[1:0] == 2'b00);

   // =======================================================================
   // State
   logic [7:0]  ctl1_r;
   logic [7:0]  ctl2_r;
   tcpp_word_t  cmp_sw_r  [2];
   tcpp_word_t  cmp_act_r [2];
   tcpp_word_t  cap_r     [2];
   tcpp_word_t  cnt_r;
   tcpp_word_t  cnt_nxt;
   logic [1:0]  inh_r;
   logic [1:0]  cinh_r;
   logic [4:0]  flg_r;
   logic [4:0]  flg_nxt;
   logic [4:0]  arm_r;
   logic [4:0]  arm_nxt;
   logic [1:0]  lat_r;
   logic [1:0]  lat_nxt;
   logic [2:0]  presc_r;
   logic        tick_d_r;
   logic        ext_d_r;
   logic        cap1_d_r;
   logic        cap2_d_r;
   logic [31:0] prdata_r;
   logic        rl_pend_r;

   // =======================================================================
   // Mode select
   tcpp_mode_t md;
   assign md = ctl2_r[`TCPP_C2_PWM]   ? TCPP_PWM :
               ctl2_r[`TCPP_C2_PULSE] ? TCPP_PULSE :
                                        TCPP_NORMAL;
   assign mode_now = md;

   wire lvl1    = ctl1_r[`TCPP_C1_LVL1];
   wire lvl2    = ctl1_r[`TCPP_C1_LVL2];
   wire [1:0] oce = {ctl2_r[`TCPP_C2_PINEN2], ctl2_r[`TCPP_C2_PINEN1]};
   wire [1:0] tsel = {ctl2_r[`TCPP_C2_TICKHI], ctl2_r[`TCPP_C2_TICKLO]};

   // =======================================================================
   // Tick generation
   wire       ext_sel = (tsel == 2'b11);
   wire       div2    = (tsel == 2'b00);
   wire [2:0] dmask   = (tsel == 2'b00) ? 3'h1 :
                        (tsel == 2'b01) ? 3'h3 : 3'h7;
   wire       ext_edg = ctl2_r[`TCPP_C2_EXEDGE] ? (ext_clk_in & ~ext_d_r)
                                                : (~ext_clk_in & ext_d_r);
   wire       tick    = ext_sel ? ext_edg
                                : ((presc_r & dmask) == dmask);

   // =======================================================================
   // Compare channels
   logic [1:0] match;
   tcpp_word_t cmp_tgt [2];
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_cmp
         assign cmp_tgt[gi] = div2 ? cmp_act_r[gi]
                                   : cmp_act_r[gi] + 16'h0001;
         assign match[gi] = tick_d_r & ~inh_r[gi]
                            & (cnt_r == cmp_tgt[gi]);
      end
   endgenerate

   wire pwm_end = (md == TCPP_PWM) & match[1];

   // =======================================================================
   // Capture inputs
   wire edge1 = ctl1_r[`TCPP_C1_EDGE1] ? (capture_input_one & ~cap1_d_r)
                                       : (~capture_input_one & cap1_d_r);
   wire edge2 = ctl2_r[`TCPP_C2_EDGE2] ? (capture_input_two & ~cap2_d_r)
                                       : (~capture_input_two & cap2_d_r);
   wire trig  = (md == TCPP_PULSE) & edge1;
   wire cap1  = (md == TCPP_NORMAL) & edge1 & ~cinh_r[0];
   wire cap2  = edge2 & ~cinh_r[1];

   // =======================================================================
   // Flags: {cap1, cmp1, ovf, cap2, cmp2}
   wire ovf = tick & (cnt_r == `TCPP_CNT_TOP);
   wire [4:0] fset = {cap1 | trig | pwm_end,
                      match[0] & (md == TCPP_NORMAL),
                      ovf,
                      cap2,
                      match[1] & (md != TCPP_PWM)};
   wire [4:0] fclr = {cap_la[0], cmp_la[0], cnt_lo, cap_la[1], cmp_la[1]}
                     & arm_r;

   assign flg_nxt = fset | (flg_r & ~fclr);
   assign arm_nxt = stat_r ? flg_r : (arm_r & ~fclr);

   // =======================================================================
   // Counter
   // Divide by two: reload on the next tick so the last count lasts a tick
   wire rl_now   = rl_pend_r & tick;
   wire rl_hold  = (pwm_end & div2) | (rl_pend_r & ~tick);
   wire cnt_load = trig | (pwm_end & ~div2) | rl_now
                   | cnt_lw;
   assign cnt_nxt = cnt_load ? `TCPP_CNT_LOAD :
                    tick     ? cnt_r + 16'h0001 : cnt_r;

   // =======================================================================
   // Output latches
   wire force_ok = (md == TCPP_NORMAL);
   wire [1:0] frc = {ctl1_r[`TCPP_C1_FORCE2], ctl1_r[`TCPP_C1_FORCE1]}
                    & oce & {2{force_ok}};

   always_comb begin
      lat_nxt = lat_r;
      case (md)
         TCPP_NORMAL: begin
            if (frc[0] | match[0])
               lat_nxt[0] = lvl1;
            if (frc[1] | match[1])
               lat_nxt[1] = lvl2;
         end
         TCPP_PULSE: begin
            if (trig)
               lat_nxt[0] = lvl2;
            else if (match[0])
               lat_nxt[0] = lvl1;
         end
         TCPP_PWM: begin
            if (match[1])
               lat_nxt[0] = lvl2;
            else if (match[0])
               lat_nxt[0] = lvl1;
         end
         default: lat_nxt = lat_r;
      endcase
   end

   assign compare_output_pin = lat_r;
   assign compare_pin_enable = oce;

   // =======================================================================
   // Interrupt merge
   assign timer_irq = ~irq_global_mask &
      ((ctl1_r[`TCPP_C1_CAPIE] & (flg_r[4] | flg_r[1])) |
       (ctl1_r[`TCPP_C1_CMPIE] & (flg_r[3] | flg_r[0])) |
       (ctl1_r[`TCPP_C1_OVFIE] & flg_r[2]));

   // =======================================================================
   // Read mux, data registered in the setup cycle
   wire [7:0] rmux =
      hit(paddr, `TCPP_CTL1_OFF)  ? ctl1_r :
      hit(paddr, `TCPP_CTL2_OFF)  ? ctl2_r :
      hit(paddr, `TCPP_STAT_OFF)  ? {flg_r, 3'h0} :
      hit(paddr, `TCPP_CMP1H_OFF) ? cmp_sw_r[0][15:8] :
      hit(paddr, `TCPP_CMP1L_OFF) ? cmp_sw_r[0][7:0] :
      hit(paddr, `TCPP_CMP2H_OFF) ? cmp_sw_r[1][15:8] :
      hit(paddr, `TCPP_CMP2L_OFF) ? cmp_sw_r[1][7:0] :
      hit(paddr, `TCPP_CAP1H_OFF) ? cap_r[0][15:8] :
      hit(paddr, `TCPP_CAP1L_OFF) ? cap_r[0][7:0] :
      hit(paddr, `TCPP_CAP2H_OFF) ? cap_r[1][15:8] :
      hit(paddr, `TCPP_CAP2L_OFF) ? cap_r[1][7:0] :
      hit(paddr, `TCPP_CNTH_OFF)  ? cnt_r[15:8] :
      hit(paddr, `TCPP_CNTL_OFF)  ? cnt_r[7:0] : 8'h00;

   assign prdata  = prdata_r;
   assign pready  = 1'b1;
   assign pslverr = acc & ~addr_ok;

   // =======================================================================
   // Register process
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl1_r    <= `TCPP_CTL_RST;
         ctl2_r    <= `TCPP_CTL_RST;
         cnt_r     <= `TCPP_CNT_LOAD;
         inh_r     <= 2'h0;
         cinh_r    <= 2'h0;
         flg_r     <= 5'h00;
         arm_r     <= 5'h00;
         lat_r     <= 2'h0;
         presc_r   <= 3'h0;
         tick_d_r  <= 1'b0;
         ext_d_r   <= 1'b0;
         cap1_d_r  <= 1'b0;
         cap2_d_r  <= 1'b0;
         prdata_r  <= 32'h0000_0000;
         rl_pend_r <= 1'b0;
      end else begin
         rl_pend_r <= rl_hold;
         if (ctl1_w)
            ctl1_r <= wbyte;
         if (ctl2_w)
            ctl2_r <= wbyte;
         cnt_r     <= cnt_nxt;
         inh_r     <= (inh_r | cmp_hw) & ~cmp_lw;
         cinh_r    <= (cinh_r | cap_hr) & ~cap_la;
         flg_r     <= flg_nxt;
         arm_r     <= arm_nxt;
         lat_r     <= lat_nxt;
         presc_r   <= presc_r + 3'h1;
         tick_d_r  <= tick;
         ext_d_r   <= ext_clk_in;
         cap1_d_r  <= capture_input_one;
         cap2_d_r  <= capture_input_two;
         if (psel & ~penable)
            prdata_r <= {24'h000000, rmux};
      end
   end

   // Compare and capture words
   generate
      for (gi = 0; gi < 2; gi++) begin : g_word
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               cmp_sw_r[gi]  <= `TCPP_CMP_RST;
               cmp_act_r[gi] <= `TCPP_CMP_RST;
            end else begin
               if (cmp_hw[gi])
                  cmp_sw_r[gi][15:8] <= wbyte;
               if (cmp_lw[gi])
                  cmp_sw_r[gi][7:0] <= wbyte;
               if (md != TCPP_PWM || pwm_end)
                  cmp_act_r[gi] <= cmp_sw_r[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cap_r[0] <= 16'h0000;
         cap_r[1] <= 16'h0000;
      end else begin
         if (trig)
            cap_r[0] <= `TCPP_CAP_PULSE;
         else if (cap1)
            cap_r[0] <= cnt_r;
         if (cap2)
            cap_r[1] <= cnt_r;
      end
   end

   // =======================================================================
   // Checks
   a_match_flag: assert property (
      @(posedge pclk) disable iff (!presetn)
      (match[0] && md == TCPP_NORMAL) |=> flg_r[3])
      else $error("compare one match did not set its flag");

   a_inhibit_hold: assert property (
      @(posedge pclk) disable iff (!presetn)
      inh_r[0] |-> !match[0])
      else $error("match while compare one inhibited");

   a_match_offset: assert property (
      @(posedge pclk) disable iff (!presetn)
      match[0] |-> (div2 ? cnt_r == cmp_act_r[0]
                         : cnt_r == cmp_act_r[0] + 16'h0001))
      else $error("compare one matched at wrong count");

   a_force_copy: assert property (
      @(posedge pclk) disable iff (!presetn)
      frc[0] |=> lat_r[0] == $past(lvl1) && !$rose(flg_r[3]))
      else $error("forced level not copied");

   a_pulse_start: assert property (
      @(posedge pclk) disable iff (!presetn)
      trig |=> cnt_r == `TCPP_CNT_LOAD && cap_r[0] == `TCPP_CAP_PULSE
               && lat_r[0] == $past(lvl2) && flg_r[4])
      else $error("one-pulse trigger effects missing");

   a_pulse_noflag: assert property (
      @(posedge pclk) disable iff (!presetn)
      md == TCPP_PULSE |-> !fset[3])
      else $error("compare one flag set in one-pulse mode");

   a_pwm_reload: assert property (
      @(posedge pclk) disable iff (!presetn)
      pwm_end && !div2 |=> cnt_r == `TCPP_CNT_LOAD ##1 !match[1])
      else $error("period end did not reload counter");

   a_reload_wait: assert property (
      @(posedge pclk) disable iff (!presetn)
      pwm_end && div2 |=> rl_pend_r)
      else $error("period end reload not held for tick");

   a_reload_apply: assert property (
      @(posedge pclk) disable iff (!presetn)
      rl_now |=> cnt_r == `TCPP_CNT_LOAD)
      else $error("held reload did not load counter");

   a_pwm_period: assert property (
      @(posedge pclk) disable iff (!presetn)
      pwm_end |=> flg_r[4])
      else $error("period end did not set capture flag one");

   a_pwm_levels: assert property (
      @(posedge pclk) disable iff (!presetn)
      (md == TCPP_PWM && match[0] && !match[1]) |=> lat_r[0] == $past(lvl1))
      else $error("modulation level one not applied");

   a_pulse_end: assert property (
      @(posedge pclk) disable iff (!presetn)
      (md == TCPP_PULSE && match[0] && !trig) |=> lat_r[0] == $past(lvl1))
      else $error("pulse end level not applied");

   a_pwm_buffer: assert property (
      @(posedge pclk) disable iff (!presetn)
      (md == TCPP_PWM && !pwm_end) |=> $stable(cmp_act_r[0]))
      else $error("active compare changed inside a period");

   a_pwm_flags: assert property (
      @(posedge pclk) disable iff (!presetn)
      md == TCPP_PWM |-> fset[3] == 1'b0 && fset[0] == 1'b0)
      else $error("compare flag set in modulation mode");

   a_irq_mask: assert property (
      @(posedge pclk) disable iff (!presetn)
      irq_global_mask |-> !timer_irq)
      else $error("interrupt raised while masked");

   a_cmp_stable: assert property (
      @(posedge pclk) disable iff (!presetn)
      !cmp_hw[0] && !cmp_lw[0] |=> $stable(cmp_sw_r[0]))
      else $error("compare one changed without a write");

endmodule
`default_nettype wire

// *** verif/tcpp_pin_model.sv ***
// Pin-side model: capture trigger drivers and external tick source
`timescale 1ns/1ps
`default_nettype none

module tcpp_pin_model (
   // Clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // Bench requests
   input  wire logic trig_one,
   input  wire logic trig_two,
   input  wire logic ext_run,
   // Pins toward the timer
   output logic      capture_input_one,
   output logic      capture_input_two,
   output logic      ext_clk_in
);
   logic [1:0] div_r;

   // Trigger levels, one transition per request change
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         capture_input_one <= 1'b0;
         capture_input_two <= 1'b0;
      end else begin
         capture_input_one <= trig_one;
         capture_input_two <= trig_two;
      end
   end

   // External tick, 8 pclk per period, still when idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r      <= 2'h0;
         ext_clk_in <= 1'b0;
      end else if (ext_run) begin
         div_r <= div_r + 2'h1;
         if (div_r == 2'h3) begin
            ext_clk_in <= ~ext_clk_in;
         end
      end
   end
endmodule
`default_nettype wire

// *** verif/tcpp_timer_test.sv ***
// Self-checking bench for the timer compare block
`timescale 1ns/1ps
`default_nettype none
`include "tcpp_defs.svh"

module tcpp_timer_test;
   import tcpp_pkg::*;
   // ==========================================================
   // Signals
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, last_err;
   logic        trig_one = 1'b0;
   logic        trig_two = 1'b0;
   logic        ext_run = 1'b0;
   logic        cap1, cap2, ext_clk, timer_irq;
   logic        irq_global_mask = 1'b0;
   logic [1:0]  pin, pin_en;
   tcpp_mode_t  mode_now;
   logic [7:0]  q, n_cmp, c1, c2;
   int          miscompares = 0;
   int          cmp_count = 0;
   int          n1, n2, e;

   always #4 pclk = ~pclk;

   tcpp_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .capture_input_one(cap1), .capture_input_two(cap2),
      .ext_clk_in(ext_clk), .compare_output_pin(pin),
      .compare_pin_enable(pin_en), .irq_global_mask(irq_global_mask),
      .timer_irq(timer_irq), .mode_now(mode_now));

   tcpp_pin_model pins (.pclk(pclk), .presetn(presetn),
      .trig_one(trig_one), .trig_two(trig_two), .ext_run(ext_run),
      .capture_input_one(cap1), .capture_input_two(cap2),
      .ext_clk_in(ext_clk));

   // ==========================================================
   // Helpers
   function automatic int tick_div(input logic [1:0] sel);
      return (sel == 2'd0) ? 2 : (sel == 2'd1) ? 4 : 8;
   endfunction

   task automatic chk(input string nm, input logic [15:0] ex,
                      input logic [15:0] got);
      cmp_count++;
      if (got !== ex) begin
         miscompares++;
         $display("Error %s expected %h seen %h", nm, ex, got);
      end
   endtask

   task automatic apb(input logic wr, input logic [7:0] a,
                      input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (!(pready === 1'b1) && n < 50);
      q        = prdata[7:0];
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (n >= 50) chk("pready", 16'h1, 16'h0);
      @(negedge pclk);
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rd(input logic [7:0] a);
      apb(1'b0, a, 8'h00);
   endtask

   // Cycles until compare pin one shows v, sampled mid-cycle
   task automatic wait_pin(input logic v, output int n);
      n = 0;
      @(negedge pclk);
      while (pin[0] !== v && n < 3000) begin
         @(negedge pclk);
         n++;
      end
      if (n >= 3000) chk("pin wait", {15'h0, v}, {15'h0, pin[0]});
   endtask

   task automatic complete_run;
      $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   initial begin
      #(8 * 60000);
      miscompares++;
      complete_run();
   end

   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(35482));
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      chk("pins in reset", 16'h0, {12'h0, pin, pin_en});
      rd(`TCPP_CMP1H_OFF); chk("cmp1 hi", 16'h80, q);
      rd(`TCPP_CMP2L_OFF); chk("cmp2 lo", 16'h00, q);
      rd(8'h34); chk("unmapped err", 16'h1, last_err);
      // Normal compare, divide by two
      n_cmp = 8'h20 + 8'($urandom_range(31));
      wr(`TCPP_CTL2_OFF, 8'h80);
      wr(`TCPP_CTL1_OFF, 8'h41);
      wr(`TCPP_CMP1H_OFF, 8'h00);
      wr(`TCPP_CMP1L_OFF, n_cmp);
      rd(`TCPP_CMP1L_OFF); chk("cmp1 rw", n_cmp, q);
      wr(`TCPP_CNTL_OFF, 8'h00);
      wait_pin(1'b1, n1);
      chk("pin en", 16'h1, pin_en[0]);
      chk("irq", 16'h1, timer_irq);
      @(posedge pclk);
      irq_global_mask <= 1'b1;
      @(negedge pclk); chk("irq masked", 16'h0, timer_irq);
      irq_global_mask <= 1'b0;
      rd(`TCPP_STAT_OFF); chk("flag set", 16'h40, q & 8'h40);
      wr(`TCPP_CMP1L_OFF, n_cmp);
      rd(`TCPP_STAT_OFF); chk("flag clear", 16'h0, q & 8'h40);
      // High byte alone inhibits the match, pin disabled
      wr(`TCPP_CTL2_OFF, 8'h00);
      wr(`TCPP_CMP1H_OFF, 8'h00);
      wr(`TCPP_CNTL_OFF, 8'h00);
      repeat (2 * n_cmp + 40) @(posedge pclk);
      rd(`TCPP_STAT_OFF); chk("inhibit", 16'h0, q & 8'h40);
      wr(`TCPP_CMP1L_OFF, n_cmp);
      wr(`TCPP_CNTL_OFF, 8'h00);
      repeat (2 * n_cmp + 40) @(posedge pclk);
      chk("pin off", 16'h0, pin_en);
      rd(`TCPP_STAT_OFF); chk("flag no pin", 16'h40, q & 8'h40);
      wr(`TCPP_CMP1L_OFF, 8'hff);
      // Forced output copies level without flag
      wr(`TCPP_CTL2_OFF, 8'h80);
      wr(`TCPP_CTL1_OFF, 8'h08);
      wait_pin(1'b0, n1);
      wr(`TCPP_CTL1_OFF, 8'h09);
      wait_pin(1'b1, n1);
      rd(`TCPP_STAT_OFF); chk("force no flag", 16'h0, q & 8'h40);
      // One-pulse on capture one, force bit left set
      wr(`TCPP_CTL1_OFF, 8'h0e);
      wr(`TCPP_CMP1L_OFF, n_cmp);
      wr(`TCPP_CTL2_OFF, 8'ha0);
      chk("mode pulse", 16'(TCPP_PULSE), 16'(mode_now));
      wait_pin(1'b0, n1);
      @(posedge pclk);
      trig_one <= 1'b1;
      wait_pin(1'b1, n1);
      wait_pin(1'b0, n2);
      @(posedge pclk);
      trig_one <= 1'b0;
      e = (n_cmp + 5) * 2;
      chk("pulse len", 16'h1, 16'(n2 >= e - 2 && n2 <= e + 2));
      rd(`TCPP_STAT_OFF); chk("pulse flags", 16'h80, q & 8'hc0);
      rd(`TCPP_CAP1H_OFF); chk("cap1 hi", 16'hff, q);
      rd(`TCPP_CAP1L_OFF); chk("cap1 lo", 16'hfd, q);
      // Modulation over every tick source
      c1 = 8'h02 + 8'($urandom_range(3));
      c2 = 8'h08 + 8'($urandom_range(7));
      wr(`TCPP_CTL1_OFF, 8'h19);
      wr(`TCPP_CMP1H_OFF, 8'h00);
      wr(`TCPP_CMP1L_OFF, c1);
      wr(`TCPP_CMP2H_OFF, 8'h00);
      wr(`TCPP_CMP2L_OFF, c2);
      @(posedge pclk);
      ext_run <= 1'b1;
      for (int s = 0; s < 4; s++) begin
         wr(`TCPP_CTL2_OFF, 8'hb1 | 8'(s << 2));
         chk("mode pwm", 16'(TCPP_PWM), 16'(mode_now));
         wr(`TCPP_CNTL_OFF, 8'h00);
         wait_pin(1'b0, n1);
         wait_pin(1'b1, n1);
         wait_pin(1'b0, n1);
         wait_pin(1'b1, n2);
         e = tick_div(2'(s));
         chk("pwm high", 16'((c2 - c1) * e), 16'(n1 + 1));
         chk("pwm period", 16'((c2 + 5) * e), 16'(n1 + n2 + 2));
         rd(`TCPP_STAT_OFF); chk("pwm flags", 16'h80, q & 8'hc8);
      end
      ext_run <= 1'b0;
      complete_run();
   end
endmodule
`default_nettype wire
